/* File: bench/core_ack_model.sv */
// Purpose: Core side of the request strobe, accepts vectors at instruction boundaries
// Assumes: Request strobe is a registered level from the dispatch block
// Notes: Acceptance can be delayed to act like a long instruction in flight
`timescale 1ns/100ps
module core_ack_model (
    input wire logic clock_in,
    input wire logic rst_b_in,
    input wire logic irq_req_in,
    input wire logic ack_en_in,
    input wire logic [3:0] ack_wait_in,
    output logic irq_ack_out
);
    // Cycles the request has been waiting
    logic [3:0] wait_reg;

    // Acknowledge once the current instruction has had time to finish
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wait_reg <= 4'h0;
            irq_ack_out <= 1'b0;
        end else begin
            // One pulse, only while the strobe is still up
            irq_ack_out <= ack_en_in && irq_req_in && !irq_ack_out && (wait_reg >= ack_wait_in);
            wait_reg <= (irq_req_in && !irq_ack_out) ? wait_reg + 4'h1 : 4'h0;
        end
    end
endmodule : core_ack_model

/* File: bench/two_level_interrupt_dispatch_test.sv */
// Purpose: Self-checking bench for the two-level interrupt dispatch block
// Assumes: Bench drives peripheral flags, return and completion strobes
// Notes: Inputs change 1 ns after each rising edge
`timescale 1ns/100ps
`include "irq_dispatch_consts.svh"
module two_level_interrupt_dispatch_test
    import irq_dispatch_pkg::*;
;
    logic clock_in = 1'b0; // System clock
    logic rst_b_in = 1'b0; // Active-low reset
    sfr_cmd_s cmd = '0; // Register access
    irq_flags_s flags = '0; // Peripheral pending flags
    logic [18:7] ext_en = '0; // Extended masks
    src_vec_t prio = '0; // Priority levels
    logic done = 1'b0, reti = 1'b0, ack_en = 1'b0, ack;
    logic [3:0] ack_wait = 4'h0; // Core acceptance delay
    logic [7:0] rdata;
    logic req, lvl;
    logic [15:0] vec;
    src_vec_t fclr;
    logic [1:0] insvc;
    int fail_count = 0, tests_run = 0, cycles = 0, idx;

    irq_dispatch i_irq_dispatch (.clock_in(clock_in), .rst_b_in(rst_b_in), .sfr_cmd_in(cmd), .sfr_rdata_out(rdata),
        .flags_in(flags), .ext_enable_in(ext_en), .priority_in(prio), .irq_ack_in(ack), .instr_done_in(done),
        .reti_in(reti), .irq_req_out(req), .irq_vector_out(vec), .irq_level_out(lvl), .flag_clear_out(fclr),
        .in_service_out(insvc));
    core_ack_model i_core_ack_model (.clock_in(clock_in), .rst_b_in(rst_b_in), .irq_req_in(req),
        .ack_en_in(ack_en), .ack_wait_in(ack_wait), .irq_ack_out(ack));

    // Free-running 10 MHz clock
    initial begin
        forever #50 clock_in = ~clock_in;
    end

    // Hang guard
    always @(posedge clock_in) begin
        cycles = cycles + 1;
        if (cycles == 5000) begin
            fail_count++;
            give_verdict();
        end
    end

    task automatic tick();
        @(posedge clock_in);
        #1;
    endtask : tick

    task automatic chk_bit(input logic g, input logic e);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("Error at %0t: bit got %b expected %b", $time, g, e);
        end
    endtask : chk_bit

    task automatic chk_val(input logic [15:0] g, input logic [15:0] e);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("Error at %0t: value got %h expected %h", $time, g, e);
        end
    endtask : chk_val

    // One register access held for one edge, then one idle edge so back-to-back calls never touch cmd twice at once
    task automatic sfr_op(input logic [7:0] a, input logic w, input logic r, input logic bw, input logic [2:0] bs,
                          input logic bv, input logic [7:0] d);
        cmd = '{addr: a, wr: w, rd: r, bit_wr: bw, bit_sel: bs, bit_val: bv, wdata: d};
        tick();
        cmd = '0;
        tick();
    endtask : sfr_op

    task automatic wr8(input logic [7:0] a, input logic [7:0] d);
        sfr_op(a, 1'b1, 1'b0, 1'b0, 3'h0, 1'b0, d);
    endtask : wr8

    task automatic rd8(input logic [7:0] a, input logic [7:0] e);
        sfr_op(a, 1'b0, 1'b1, 1'b0, 3'h0, 1'b0, 8'h00);
        chk_val({8'h00, rdata}, {8'h00, e});
    endtask : rd8

    // Core strobes: return and instruction completion
    task automatic core_evt(input logic r, input logic d);
        reti = r;
        done = d;
        tick();
        reti = 1'b0;
        done = 1'b0;
    endtask : core_evt

    task automatic wait_svc(input logic [1:0] e);
        int n;
        for (n = 0; n < 20 && insvc !== e; n++) tick();
        chk_val({14'h0000, insvc}, {14'h0000, e});
    endtask : wait_svc

    task automatic give_verdict();
        if (fail_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict

    // Main sequence
    initial begin
        repeat (10) @(posedge clock_in);
        #1 rst_b_in = 1'b1;
        chk_val(vec, `RESET_VECTOR);
        rd8(`IRQ_MASK_ADDR, 8'h00);
        wr8(`IRQ_MASK_ADDR, 8'h81);
        rd8(`IRQ_MASK_ADDR, 8'h81);
        wr8(8'hA9, 8'hFF);
        rd8(8'hA9, 8'h00);
        sfr_op(`IRQ_MASK_ADDR, 1'b0, 1'b0, 1'b1, 3'h7, 1'b0, 8'h00);
        rd8(`IRQ_MASK_ADDR, 8'h01);
        // Flag set while globally disabled stays pending
        flags.ext_line0_pending = 1'b1;
        repeat (3) tick();
        chk_bit(req, 1'b0);
        sfr_op(`IRQ_MASK_ADDR, 1'b0, 1'b0, 1'b1, 3'h7, 1'b1, 8'h00);
        chk_bit(req, 1'b1);
        flags = '0;
        tick();
        // Fresh flag: request rises exactly one edge after it is seen
        flags.ext_line0_pending = 1'b1;
        chk_bit(req, 1'b0);
        tick();
        chk_bit(req, 1'b1);
        flags = '0;
        tick();
        // Each flag alone: masked, then unmasked, with its vector
        for (int b = 0; b < 21; b++) begin
            idx = b <= 5 ? b : b == 6 ? 5 : b <= 16 ? b - 1 : b == 17 ? 15 : b - 2;
            flags = irq_flags_s'(21'h1 << b);
            ext_en = ~(12'h001 << (idx - 7));
            wr8(`IRQ_MASK_ADDR, {1'b1, ~(7'h01 << idx)});
            tick();
            chk_bit(req, 1'b0);
            ext_en = ~ext_en;
            wr8(`IRQ_MASK_ADDR, {1'b1, 7'h01 << idx});
            tick();
            chk_bit(req, 1'b1);
            chk_val(vec, `VEC_BASE + 16'(idx * 8));
            flags = '0;
            tick();
        end
        // Simultaneous requests: fixed order, then high level first
        ext_en = '1;
        wr8(`IRQ_MASK_ADDR, 8'hFF);
        flags = '1;
        tick();
        chk_val(vec, `VEC_BASE);
        chk_bit(lvl, 1'b0);
        prio = src_vec_t'(1) << 18;
        tick();
        chk_val(vec, `VEC_LAST);
        chk_bit(lvl, 1'b1);
        prio = '0;
        flags = '0;
        tick();
        // Accept low request, hardware clear pulse
        flags.ext_line0_pending = 1'b1;
        flags.serial_pending = 1'b1;
        ack_en = 1'b1;
        wait_svc(2'b01);
        chk_val({12'h000, fclr[3:0]}, 16'h0001);
        chk_bit(|fclr[18:4], 1'b0);
        flags.ext_line0_pending = 1'b0;
        ack_en = 1'b0;
        repeat (3) tick();
        chk_bit(req, 1'b0);
        // High request preempts the low routine
        prio[3] = 1'b1;
        flags.timer1_overflow_flag = 1'b1;
        tick();
        chk_bit(req, 1'b1);
        chk_val(vec, 16'h001B);
        ack_wait = 4'h3;
        ack_en = 1'b1;
        wait_svc(2'b11);
        chk_val({12'h000, fclr[3:0]}, 16'h0008);
        flags.timer1_overflow_flag = 1'b0;
        ack_en = 1'b0;
        prio[1] = 1'b1;
        flags.timer0_overflow_flag = 1'b1;
        repeat (3) tick();
        chk_bit(req, 1'b0);
        flags.timer0_overflow_flag = 1'b0;
        // Returns: high level first, then one instruction before re-entry
        core_evt(1'b1, 1'b0);
        chk_val({14'h0000, insvc}, 16'h0001);
        tick();
        core_evt(1'b1, 1'b0);
        chk_val({14'h0000, insvc}, 16'h0000);
        repeat (2) tick();
        chk_bit(req, 1'b0);
        core_evt(1'b0, 1'b1);
        chk_bit(req, 1'b0);
        tick();
        chk_bit(req, 1'b1);
        chk_val(vec, 16'h0023);
        give_verdict();
    end
endmodule : two_level_interrupt_dispatch_test

/* File: hdl/irq_dispatch.sv */
// Purpose: Two-level interrupt dispatch for a pipelined 8-bit core
// Assumes: Flags and core strobes come from logic on clock_in
// Notes: Extended enables and priorities arrive as plain inputs
`timescale 1ns/100ps
`include "irq_dispatch_consts.svh"
module irq_dispatch
    import irq_dispatch_pkg::*;
(
    input wire logic clock_in,
    input wire logic rst_b_in,
    input wire sfr_cmd_s sfr_cmd_in,
    output logic [7:0] sfr_rdata_out,
    input wire irq_flags_s flags_in,
    input wire logic [`NUM_SRC-1:`IRQ_MASK_LOCAL_MSB+1] ext_enable_in,
    input wire src_vec_t priority_in,
    input wire logic irq_ack_in,
    input wire logic instr_done_in,
    input wire logic reti_in,
    output logic irq_req_out,
    output logic [15:0] irq_vector_out,
    output logic irq_level_out,
    output src_vec_t flag_clear_out,
    output logic [1:0] in_service_out
);
    logic [7:0] interrupt_enable_mask_reg; // Enable register
    logic [7:0] interrupt_enable_mask_next; // Its next value
    logic global_irq_enable; // Master enable bit
    logic in_svc_hi_reg; // High-level routine running
    logic in_svc_lo_reg; // Low-level routine running
    svc_phase_e phase_reg; // Return tracking phase
    src_vec_t pending; // Raw pending per source
    src_vec_t enable; // Per-source mask
    src_vec_t eligible; // Enabled pending requests
    logic hi_found, lo_found; // Arbiter results
    logic [`SRC_IDX_W-1:0] hi_idx, lo_idx;
    logic cand; // A request may be raised
    logic cand_level; // Level of the winner
    logic [`SRC_IDX_W-1:0] cand_idx; // Winner index
    logic [`SRC_IDX_W-1:0] taken_idx_reg; // Index behind the strobe
    logic taken; // Core accepted the vector

    // Gather flags into fixed order, merged groups share a slot
    always_comb begin
        pending = {flags_in.spi_port1_pending, flags_in.rtc_osc_fail_pending,
                   flags_in.port_match_pending,
                   flags_in.core_supply_ok_pending | flags_in.battery_supply_ok_pending,
                   flags_in.analog_timer_pending, flags_in.rtc_alarm_pending,
                   flags_in.smbus_pending, flags_in.spi_port0_pending,
                   flags_in.timer2_high_overflow_flag | flags_in.timer2_low_overflow_flag,
                   flags_in.serial_pending, flags_in.timer1_overflow_flag,
                   flags_in.ext_line1_pending, flags_in.timer0_overflow_flag,
                   flags_in.ext_line0_pending};
    end

    // Masks: low seven from the register, rest external
    assign global_irq_enable = interrupt_enable_mask_reg[`IRQ_MASK_GLOBAL_BIT];
    assign enable = {ext_enable_in, interrupt_enable_mask_reg[`IRQ_MASK_LOCAL_MSB:0]};
    // Flags stay pending outside, gated here only
    assign eligible = global_irq_enable ? (pending & enable) : '0;

    // One picker per level, fixed order inside each
    irq_fixed_order_pick u_pick_hi (
        .req_in(eligible & priority_in),
        .found_out(hi_found),
        .idx_out(hi_idx)
    );
    irq_fixed_order_pick u_pick_lo (
        .req_in(eligible & ~priority_in),
        .found_out(lo_found),
        .idx_out(lo_idx)
    );

    // Level decode each cycle with preemption limits
    always_comb begin
        cand = 1'b0;
        cand_level = 1'b0;
        cand_idx = hi_idx;
        if (phase_reg == PH_POST_RETI) begin
            // Hold off until the instruction after return
            cand = 1'b0;
        end else if (hi_found && !in_svc_hi_reg) begin
            cand = 1'b1;
            cand_level = 1'b1;
        end else if (lo_found && !in_svc_hi_reg && !in_svc_lo_reg) begin
            cand = 1'b1;
            cand_idx = lo_idx;
        end
    end

    assign taken = irq_req_out && irq_ack_in;

    // Request strobe, vector and level, registered once: the detect cycle
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            irq_req_out <= 1'b0;
            irq_vector_out <= `RESET_VECTOR;
            irq_level_out <= 1'b0;
            taken_idx_reg <= '0;
        end else begin
            irq_req_out <= cand && !taken;
            if (cand && !taken) begin
                irq_vector_out <= `VEC_BASE + (16'(cand_idx) << `VEC_SHIFT);
                irq_level_out <= cand_level;
                taken_idx_reg <= cand_idx;
            end
        end
    end

    // Hardware flag clear on vectoring for the four auto-cleared sources
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            flag_clear_out <= '0;
        end else begin
            flag_clear_out <= '0;
            if (taken && taken_idx_reg <= `HW_CLEAR_LAST) begin
                flag_clear_out[taken_idx_reg] <= 1'b1;
            end
        end
    end

    // In-service bits: set on acceptance unless a return comes in the same cycle, return clears the higher one
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            in_svc_hi_reg <= 1'b0;
            in_svc_lo_reg <= 1'b0;
        end else begin
            if (reti_in) begin
                if (in_svc_hi_reg) begin
                    in_svc_hi_reg <= 1'b0;
                end else begin
                    in_svc_lo_reg <= 1'b0;
                end
            end else if (taken) begin
                if (irq_level_out) begin
                    in_svc_hi_reg <= 1'b1;
                end else begin
                    in_svc_lo_reg <= 1'b1;
                end
            end
        end
    end
    assign in_service_out = {in_svc_hi_reg, in_svc_lo_reg};

    // Return phase: one full instruction runs before the next call
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            phase_reg <= PH_RUN;
        end else begin
            case (phase_reg)
                PH_RUN: begin
                    if (reti_in) begin
                        phase_reg <= PH_POST_RETI;
                    end
                end
                PH_POST_RETI: begin
                    if (instr_done_in) begin
                        phase_reg <= PH_RUN;
                    end
                end
                default: begin
                    phase_reg <= PH_RUN;
                end
            endcase
        end
    end

    // Enable register write: byte or single bit, same address on every page
    always_comb begin
        interrupt_enable_mask_next = interrupt_enable_mask_reg;
        if (sfr_cmd_in.addr == `IRQ_MASK_ADDR) begin
            if (sfr_cmd_in.wr) begin
                interrupt_enable_mask_next = sfr_cmd_in.wdata;
            end else if (sfr_cmd_in.bit_wr) begin
                interrupt_enable_mask_next[sfr_cmd_in.bit_sel] = sfr_cmd_in.bit_val;
            end
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            interrupt_enable_mask_reg <= `IRQ_MASK_RESET;
        end else begin
            interrupt_enable_mask_reg <= interrupt_enable_mask_next;
        end
    end

    // Read data: the enable register, zero for other addresses
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sfr_rdata_out <= 8'h00;
        end else if (sfr_cmd_in.rd) begin
            sfr_rdata_out <= (sfr_cmd_in.addr == `IRQ_MASK_ADDR) ? interrupt_enable_mask_reg : 8'h00;
        end
    end

    // Checks
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_b_in);

    sequence s_vector_taken;
        irq_req_out && irq_ack_in;
    endsequence
    sequence s_reti_then_wait;
        reti_in ##1 !instr_done_in;
    endsequence

    a_req_needs_global: assert property (irq_req_out |-> $past(global_irq_enable))
        else $error("request raised while globally disabled");
    a_no_call_post_reti: assert property (s_reti_then_wait |=> !irq_req_out)
        else $error("request before the instruction after return");
    a_hw_clear_pulse: assert property (s_vector_taken ##0 (taken_idx_reg <= `HW_CLEAR_LAST)
        |=> flag_clear_out[$past(taken_idx_reg)])
        else $error("auto-cleared flag not cleared on vectoring");
    a_no_clear_others: assert property (flag_clear_out[`NUM_SRC-1:4] == '0)
        else $error("flag cleared for a software-cleared source");
    a_vector_layout: assert property (irq_req_out |-> irq_vector_out[2:0] == 3'h3
        && irq_vector_out <= `VEC_LAST)
        else $error("vector outside the table");
    a_high_not_preempted: assert property (in_svc_hi_reg |-> !cand)
        else $error("high-level routine preempted");
    // Index 0 only wins when no other high-level source outranks it
    a_detect_one_cycle: assert property ((phase_reg == PH_RUN && !in_svc_hi_reg && !in_svc_lo_reg
        && global_irq_enable && enable[0] && pending[0] && !irq_req_out && (priority_in[0] || !hi_found))
        |=> irq_req_out
        && irq_vector_out == `VEC_BASE)
        else $error("request not raised one cycle after detect");
    a_low_waits_low: assert property (in_svc_lo_reg && irq_req_out |-> irq_level_out)
        else $error("equal level request during low routine");
    a_taken_sets_service: assert property (s_vector_taken ##0 !reti_in |=> in_service_out != 2'b00)
        else $error("acceptance did not mark a routine in service");
endmodule : irq_dispatch

/* File: hdl/irq_dispatch_consts.svh */
// Purpose: Constants for the two-level interrupt dispatch block
// Assumes: One system clock, cycle counts given in system clocks
// Notes: Included by the package and by the design modules
`ifndef IRQ_DISPATCH_CONSTS_SVH
`define IRQ_DISPATCH_CONSTS_SVH
// Enable register address and layout
`define IRQ_MASK_ADDR 8'hA8
`define IRQ_MASK_RESET 8'h00
`define IRQ_MASK_GLOBAL_BIT 7
`define IRQ_MASK_LOCAL_MSB 6
// Source count and vector layout
`define NUM_SRC 19
`define SRC_IDX_W 5
`define HW_CLEAR_LAST 5'h03
`define RESET_VECTOR 16'h0000
`define VEC_BASE 16'h0003
`define VEC_SHIFT 3
`define VEC_LAST 16'h0093
// Response figures in system clocks
`define DETECT_CYCLES 1
`define LCALL_CYCLES 5
`define RETI_CYCLES 5
`define DIV_CYCLES 8
`define BEST_RESPONSE (`DETECT_CYCLES + 1 + `LCALL_CYCLES)
`define WORST_RESPONSE (`DETECT_CYCLES + `RETI_CYCLES + `DIV_CYCLES + `LCALL_CYCLES)
`endif

/* File: hdl/irq_dispatch_pkg.sv */
// Purpose: Types shared by the interrupt dispatch modules
// Assumes: Constants header is available on the include path
// Notes: Holds types only
package irq_dispatch_pkg;
`include "irq_dispatch_consts.svh"

    // Special-register access from the core
    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic bit_wr;
        logic [2:0] bit_sel;
        logic bit_val;
        logic [7:0] wdata;
    } sfr_cmd_s;

    // Pending flags from peripherals, listed in fixed order
    typedef struct packed {
        logic spi_port1_pending;
        logic rtc_osc_fail_pending;
        logic port_match_pending;
        logic battery_supply_ok_pending;
        logic core_supply_ok_pending;
        logic [5:0] analog_timer_pending;
        logic rtc_alarm_pending;
        logic smbus_pending;
        logic spi_port0_pending;
        logic timer2_high_overflow_flag;
        logic timer2_low_overflow_flag;
        logic serial_pending;
        logic timer1_overflow_flag;
        logic ext_line1_pending;
        logic timer0_overflow_flag;
        logic ext_line0_pending;
    } irq_flags_s;

    // Phase after a return instruction
    typedef enum logic [1:0] {
        PH_RUN = 2'b01,
        PH_POST_RETI = 2'b10
    } svc_phase_e;

    typedef logic [`NUM_SRC-1:0] src_vec_t;
endpackage : irq_dispatch_pkg

/* File: hdl/irq_fixed_order_pick.sv */
// Purpose: Pick the lowest-index request of a vector
// Assumes: Purely combinational
// Notes: Used once per priority level
`timescale 1ns/100ps
`include "irq_dispatch_consts.svh"
module irq_fixed_order_pick
    import irq_dispatch_pkg::*;
(
    input wire src_vec_t req_in,
    output logic found_out,
    output logic [`SRC_IDX_W-1:0] idx_out
);
    // Scan from highest index down so index 0 wins last
    always_comb begin
        found_out = 1'b0;
        idx_out = '0;
        for (int i = `NUM_SRC - 1; i >= 0; i--) begin
            if (req_in[i]) begin
                found_out = 1'b1;
                idx_out = i[`SRC_IDX_W-1:0];
            end
        end
    end
endmodule : irq_fixed_order_pick
